/* File: testbench/btm_tgt_model.sv */
// Target bus model: drives run level and bus cycles seen by the monitor
`timescale 1ns/100ps
module btm_tgt_model (
    // Clock
    input wire logic core_clk,
    // Target bus
    output logic tgt_run,
    output logic tgt_strb,
    output logic tgt_wr,
    output logic [btm_pkg::AW-1:0] tgt_addr,
    output logic [btm_pkg::DW-1:0] tgt_data
);
    initial begin
        tgt_run = 1'b0;
        tgt_strb = 1'b0;
        tgt_wr = 1'b0;
        tgt_addr = 24'h000000;
        tgt_data = 16'h0000;
    end

    // Settle time around run edges so records land before the level changes
    task set_run(input logic v);
        repeat (6) @(posedge core_clk);
        tgt_run <= v;
        repeat (6) @(posedge core_clk);
    endtask : set_run

    // Strobe high for len samples, then low; back-to-back cycles leave two low samples between them
    task bus_cycle(input logic [23:0] a, input logic [15:0] d, input logic w, input int len);
        @(posedge core_clk);
        tgt_strb <= 1'b1;
        tgt_addr <= a;
        tgt_data <= d;
        tgt_wr <= w;
        repeat (len) @(posedge core_clk);
        tgt_strb <= 1'b0;
        // Lines are not held after the cycle: show the inverse, never the old value
        tgt_addr <= ~a;
        tgt_data <= ~d;
        tgt_wr <= ~w;
        @(posedge core_clk);
    endtask : bus_cycle
endmodule : btm_tgt_model

/* File: testbench/tb.sv */
// Testbench for the bus trigger and trace monitor
`timescale 1ns/100ps
module tb;
    logic core_clk;
    logic nrst;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    logic tgt_run, tgt_strb, tgt_wr;
    logic [23:0] tgt_addr;
    logic [15:0] tgt_data;
    logic [3:0] probe_pin;
    int miscompares = 0;
    int total_checks = 0;
    int cyc = 0;

    always #4 core_clk = ~core_clk;

    btm_tgt_model tgt (.core_clk(core_clk), .tgt_run(tgt_run), .tgt_strb(tgt_strb),
        .tgt_wr(tgt_wr), .tgt_addr(tgt_addr), .tgt_data(tgt_data));
    btm_monitor uut (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .tgt_run(tgt_run), .tgt_strb(tgt_strb), .tgt_wr(tgt_wr), .tgt_addr(tgt_addr),
        .tgt_data(tgt_data), .probe_pin(probe_pin));

    task close_out;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out

    // Hang guard: the full sequence needs well under 5000 cycles
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            close_out();
        end
    end

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr_reg

    task rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(what, exp, reg_rdata);
    endtask : rd_chk

    function automatic logic [23:0] addr_of(input int i);
        return 24'h0A0000 + 24'(i * 'h124);
    endfunction : addr_of

    // Runs one bus cycle, collecting which probes rose and how long they stood
    task probe_cycle(input logic [23:0] a, input int len, input logic [3:0] exp);
        logic [3:0] seen;
        int hi;
        seen = 4'h0;
        hi = 0;
        fork
            tgt.bus_cycle(a, 16'h5A3C, 1'b0, len);
            repeat (len + 6) begin
                @(posedge core_clk);
                #1 seen = seen | probe_pin;
                if (probe_pin != 4'h0) hi++;
            end
        join
        chk("probes raised", 32'(exp), 32'(seen));
        chk("probe high cycles", (exp != 4'h0) ? len : 0, hi);
        chk("probes idle", 32'h0, 32'(probe_pin));
    endtask : probe_cycle

    task t_reset;
        rd_chk("enables", btm_pkg::OFS_ENA, 32'h0);
        for (int i = 0; i < 4; i++) begin
            rd_chk("match addr", btm_pkg::OFS_ADDR0 + 8'(4 * i), 32'h0);
        end
        rd_chk("count", btm_pkg::OFS_CNT, 32'h0);
        wr_reg(8'h3C, 32'hFFFFFFFF);
        rd_chk("unmapped", 8'h3C, 32'h0);
    endtask : t_reset

    task t_trigger;
        for (int i = 0; i < 4; i++) wr_reg(btm_pkg::OFS_ADDR0 + 8'(4 * i), 32'(addr_of(i)));
        for (int i = 0; i < 4; i++) begin
            rd_chk("match addr", btm_pkg::OFS_ADDR0 + 8'(4 * i), 32'(addr_of(i)));
        end
        wr_reg(btm_pkg::OFS_ENA, 32'hF);
        tgt.set_run(1'b1);
        for (int i = 0; i < 4; i++) probe_cycle(addr_of(i), 2 + i, 4'(1 << i));
        probe_cycle(24'h0B0000, 3, 4'h0);
    endtask : t_trigger

    task t_disable;
        wr_reg(btm_pkg::OFS_CLR, 32'h2);
        rd_chk("enables", btm_pkg::OFS_ENA, 32'hD);
        probe_cycle(addr_of(1), 3, 4'h0);
        rd_chk("kept addr", btm_pkg::OFS_ADDR1, 32'(addr_of(1)));
        wr_reg(btm_pkg::OFS_ENA, 32'hF);
        probe_cycle(addr_of(1), 3, 4'h2);
        wr_reg(btm_pkg::OFS_CLR, 32'(1 << btm_pkg::CLR_ALL_BIT));
        rd_chk("enables", btm_pkg::OFS_ENA, 32'h0);
        for (int i = 0; i < 4; i++) probe_cycle(addr_of(i), 2, 4'h0);
    endtask : t_disable

    // Probes stay low while the program is halted, even with all channels enabled
    task t_halt;
        wr_reg(btm_pkg::OFS_ENA, 32'hF);
        tgt.set_run(1'b0);
        probe_cycle(addr_of(0), 3, 4'h0);
        wr_reg(btm_pkg::OFS_CLR, 32'hF);
        rd_chk("enables", btm_pkg::OFS_ENA, 32'h0);
    endtask : t_halt

    // Three records with lengths at the code edges: 1, 8 and one past 8
    task t_trace;
        int lens [3];
        logic [48:0] r;
        lens = '{1, 8, 9};
        tgt.set_run(1'b0);
        tgt.set_run(1'b1);
        rd_chk("status run", btm_pkg::OFS_STAT, 32'h100);
        for (int i = 0; i < 3; i++) begin
            tgt.bus_cycle(addr_of(i + 5), 16'(16'hC3A0 + i), 1'(i), lens[i]);
        end
        tgt.set_run(1'b0);
        rd_chk("count", btm_pkg::OFS_CNT, 32'h3);
        tgt.bus_cycle(addr_of(9), 16'h1234, 1'b1, 2);
        tgt.set_run(1'b0);
        rd_chk("count halted", btm_pkg::OFS_CNT, 32'h3);
        for (int k = 0; k < 3; k++) begin
            r = {(lens[2 - k] > 8) ? btm_pkg::CLK_OVR : 4'(lens[2 - k]), 4'h0, 1'(2 - k),
                16'(16'hC3A0 + 2 - k), addr_of(7 - k)};
            wr_reg(btm_pkg::OFS_TSEL, 32'(k));
            @(posedge core_clk);
            rd_chk("record low", btm_pkg::OFS_TLO, r[31:0]);
            rd_chk("record high", btm_pkg::OFS_THI, 32'(r[48:32]));
        end
        rd_chk("trace select", btm_pkg::OFS_TSEL, 32'h2);
    endtask : t_trace

    initial begin
        core_clk = 1'b0;
        nrst = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h00000000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        t_reset();
        t_trigger();
        t_disable();
        t_halt();
        t_trace();
        close_out();
    end
endmodule : tb

/* File: verilog/btm_monitor.sv */
// Bus trigger channels and free-running trace capture for an emulated target bus
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/100ps
// Notes on behaviour
// RULE1 - Four independent channels, each comparing bus addresses to its own address.
// RULE2 - Enabled channel matching a read or write cycle drives its probe pin high.
// RULE3 - A channel with enable cleared never raises its probe pin.
// RULE4 - Each channel holds a host-programmable match address used while the program runs.
// RULE5 - Disabling keeps the programmed address; no event until enabled again.
// RULE6 - Channels are never removed; clear one or all just disables them.
// RULE7 - Trace capture in hardware per bus cycle, never stalling the target.
// RULE8 - Buffer holds latest 32768 cycle records of the last run, always updated.
// RULE9 - With no acquisition condition, every bus cycle is recorded.
// RULE10 - Recording starts when the program starts and stops when it halts.
// RULE11 - Each record carries cycle length 1 to 8 or an overflow code.
// RULE12 - Records are read relative to the newest, which is index zero.
// RULE13 - Probe stays high during the matching cycle, drops when next one misses; here it drops when the strobe of the matching cycle ends.
module btm_monitor (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Monitored target bus
    input wire logic tgt_run,
    input wire logic tgt_strb,
    input wire logic tgt_wr,
    input wire logic [btm_pkg::AW-1:0] tgt_addr,
    input wire logic [btm_pkg::DW-1:0] tgt_data,
    // Second external probe connector pins 1..4
    output logic [btm_pkg::NCH-1:0] probe_pin
);

    logic [btm_pkg::SY_W-1:0] sy1_q;
    logic [btm_pkg::SY_W-1:0] sy2_q;
    logic strb_p_q;
    logic run_p_q;
    logic [btm_pkg::NCH-1:0] ena_q;
    logic [btm_pkg::AW-1:0] match_q [btm_pkg::NCH];
    logic [btm_pkg::NCH-1:0] trig_q;
    logic [3:0] clk_q;
    logic [btm_pkg::AW-1:0] lat_addr_q;
    logic [btm_pkg::DW-1:0] lat_data_q;
    logic lat_wr_q;
    logic [btm_pkg::PW-1:0] wptr_q;
    logic [btm_pkg::CW-1:0] cnt_q;
    logic [btm_pkg::PW-1:0] tsel_q;
    logic [btm_pkg::REC_W-1:0] trace_mem [btm_pkg::DEPTH];
    logic [btm_pkg::REC_W-1:0] mem_rd_q;
    logic [31:0] rdata_q;
    logic [3:0] slen_q;

    logic strb;
    logic run;
    logic [btm_pkg::AW-1:0] addr;
    logic cyc_end;
    logic run_start;
    logic rec_en;
    logic [btm_pkg::REC_W-1:0] rec_d;
    logic [btm_pkg::PW-1:0] raddr;
    logic [btm_pkg::NCH-1:0] hit;

    // Cycle length code for the record; long cycles fold into one code
    function automatic logic [3:0] clk_code(input logic [3:0] n);
        clk_code = (n > btm_pkg::CLK_MAX) ? btm_pkg::CLK_OVR : n;
    endfunction : clk_code

    // Address decode, also used by the checks below
    function automatic logic is_ofs(input logic [7:0] a, input logic [7:0] o);
        is_ofs = (a == o);
    endfunction : is_ofs

    assign strb = sy2_q[btm_pkg::SY_STRB];
    assign run = sy2_q[btm_pkg::SY_RUN];
    assign addr = sy2_q[btm_pkg::SY_ADDR +: btm_pkg::AW];
    assign cyc_end = strb_p_q & ~strb;
    assign run_start = run & ~run_p_q;
    assign rec_en = cyc_end & run; // RULE9 RULE10
    assign raddr = wptr_q - tsel_q - 15'h0001; // RULE12
    assign probe_pin = trig_q;
    assign reg_rdata = rdata_q;

    // Pins from the target are asynchronous to the monitor clock
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sy1_q <= '0;
            sy2_q <= '0;
        end else begin
            sy1_q <= {tgt_run, tgt_strb, tgt_wr, tgt_data, tgt_addr};
            sy2_q <= sy1_q;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            strb_p_q <= 1'b0;
            run_p_q <= 1'b0;
        end else begin
            strb_p_q <= strb;
            run_p_q <= run;
        end
    end

    // Enables; clearing never touches the stored addresses
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ena_q <= btm_pkg::ENA_RST;
        end else if (reg_wr && is_ofs(reg_addr, btm_pkg::OFS_ENA)) begin
            ena_q <= reg_wdata[btm_pkg::NCH-1:0]; // RULE3
        end else if (reg_wr && is_ofs(reg_addr, btm_pkg::OFS_CLR)) begin
            if (reg_wdata[btm_pkg::CLR_ALL_BIT]) begin
                ena_q <= '0; // RULE6
            end else begin
                ena_q <= ena_q & ~reg_wdata[btm_pkg::NCH-1:0]; // RULE6 RULE5
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < btm_pkg::NCH; i++) begin
                match_q[i] <= btm_pkg::ADDR_RST;
            end
        end else if (reg_wr) begin
            if (is_ofs(reg_addr, btm_pkg::OFS_ADDR0)) begin
                match_q[0] <= reg_wdata[btm_pkg::AW-1:0]; // RULE4
            end
            if (is_ofs(reg_addr, btm_pkg::OFS_ADDR1)) begin
                match_q[1] <= reg_wdata[btm_pkg::AW-1:0]; // RULE4
            end
            if (is_ofs(reg_addr, btm_pkg::OFS_ADDR2)) begin
                match_q[2] <= reg_wdata[btm_pkg::AW-1:0]; // RULE4
            end
            if (is_ofs(reg_addr, btm_pkg::OFS_ADDR3)) begin
                match_q[3] <= reg_wdata[btm_pkg::AW-1:0]; // RULE4
            end
        end
    end

    // Per-channel compare, live only while the program runs
    always_comb begin
        for (int i = 0; i < btm_pkg::NCH; i++) begin
            hit[i] = strb & run & ena_q[i] & (addr == match_q[i]); // RULE1 RULE2 RULE3 RULE5
        end
    end

    // Probe follows the strobe, so it falls as soon as a cycle ends or misses
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            trig_q <= '0;
        end else begin
            trig_q <= hit; // RULE2 RULE13
        end
    end

    // Cycle length counter saturates one past the largest direct code
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            clk_q <= 4'h0;
        end else if (strb && !strb_p_q) begin
            clk_q <= 4'h1;
        end else if (strb && clk_q != btm_pkg::CLK_SAT) begin
            clk_q <= clk_q + 4'h1; // RULE11
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            lat_addr_q <= btm_pkg::ADDR_RST;
            lat_data_q <= '0;
            lat_wr_q <= 1'b0;
        end else if (strb) begin
            lat_addr_q <= addr;
            lat_data_q <= sy2_q[btm_pkg::SY_DATA +: btm_pkg::DW];
            lat_wr_q <= sy2_q[btm_pkg::SY_WR];
        end
    end

    // Probe state still shows the ending cycle when the record is taken
    assign rec_d = {clk_code(clk_q), trig_q, lat_wr_q, lat_data_q, lat_addr_q}; // RULE11

    // Write pointer wraps, so the oldest record is overwritten first
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wptr_q <= btm_pkg::PTR_RST;
            cnt_q <= btm_pkg::CNT_RST;
        end else if (run_start) begin
            wptr_q <= btm_pkg::PTR_RST; // RULE10
            cnt_q <= btm_pkg::CNT_RST;
        end else if (rec_en) begin
            wptr_q <= wptr_q + 15'h0001; // RULE8
            if (cnt_q != btm_pkg::CNT_FULL) begin
                cnt_q <= cnt_q + 16'h0001;
            end
        end
    end

    // Trace store has no stall path back to the target
    always_ff @(posedge core_clk) begin
        if (rec_en) begin
            trace_mem[wptr_q] <= rec_d; // RULE7 RULE8
        end
        mem_rd_q <= trace_mem[raddr];
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            tsel_q <= btm_pkg::PTR_RST;
        end else if (reg_wr && is_ofs(reg_addr, btm_pkg::OFS_TSEL)) begin
            tsel_q <= reg_wdata[btm_pkg::PW-1:0]; // RULE12
        end
    end

    // Read data stands only in the cycle after the read strobe
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= btm_pkg::RD_RST;
        end else if (reg_rd) begin
            case (reg_addr)
                btm_pkg::OFS_ENA: rdata_q <= {28'h0000000, ena_q};
                btm_pkg::OFS_ADDR0: rdata_q <= {8'h00, match_q[0]};
                btm_pkg::OFS_ADDR1: rdata_q <= {8'h00, match_q[1]};
                btm_pkg::OFS_ADDR2: rdata_q <= {8'h00, match_q[2]};
                btm_pkg::OFS_ADDR3: rdata_q <= {8'h00, match_q[3]};
                btm_pkg::OFS_STAT: rdata_q <= {23'h000000, run, trig_q, ena_q};
                btm_pkg::OFS_CNT: rdata_q <= {16'h0000, cnt_q};
                btm_pkg::OFS_TSEL: rdata_q <= {17'h00000, tsel_q};
                btm_pkg::OFS_TLO: rdata_q <= mem_rd_q[31:0];
                btm_pkg::OFS_THI: rdata_q <= {15'h0000, mem_rd_q[48:32]};
                default: rdata_q <= btm_pkg::RD_RST;
            endcase
        end else begin
            rdata_q <= btm_pkg::RD_RST;
        end
    end

    // Separate strobe length count for the checks, so they do not trust clk_q
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            slen_q <= 4'h0;
        end else if (!strb) begin
            slen_q <= 4'h0;
        end else if (slen_q != 4'hF) begin
            slen_q <= slen_q + 4'h1;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    AST_PROBE_HIT: assert property ( // RULE2
        hit[0] |=> probe_pin[0])
        else $error("probe 1 missed an enabled match");
    AST_PROBE_DISABLED: assert property ( // RULE3
        !ena_q[2] |=> !probe_pin[2])
        else $error("disabled channel 3 drove its probe");
    AST_PROBE_DROP: assert property ( // RULE13
        !strb |=> probe_pin == 4'h0)
        else $error("probe high outside a bus cycle");
    AST_CLEAR_ALL: assert property ( // RULE6
        reg_wr && is_ofs(reg_addr, btm_pkg::OFS_CLR) && reg_wdata[4] |=> ena_q == 4'h0)
        else $error("clear all left a channel enabled");
    AST_KEEP_ADDR: assert property ( // RULE5
        reg_wr && is_ofs(reg_addr, btm_pkg::OFS_CLR) |=> $stable(match_q[1]))
        else $error("disabling changed a match address");
    AST_PTR_STEP: assert property ( // RULE8
        rec_en && !run_start |=> wptr_q == $past(wptr_q) + 15'h0001)
        else $error("record not written on a finished cycle");
    AST_HALT_FREEZE: assert property ( // RULE10
        !run |=> $stable(wptr_q))
        else $error("trace moved while halted");
    AST_START_CLEAR: assert property ( // RULE10
        run_start |=> wptr_q == 15'h0000 && cnt_q == 16'h0000)
        else $error("run start did not restart the trace");
    AST_LONG_CYCLE: assert property ( // RULE11
        cyc_end && slen_q > btm_pkg::CLK_MAX |-> rec_d[btm_pkg::REC_CLK +: 4] == btm_pkg::CLK_OVR)
        else $error("long cycle not marked overflow");
    AST_CYCLE_LEN: assert property ( // RULE11
        cyc_end && slen_q <= btm_pkg::CLK_MAX |-> rec_d[btm_pkg::REC_CLK +: 4] == slen_q)
        else $error("cycle length code differs from strobe length");
    AST_RUN_GATE: assert property ( // RULE4
        !run |=> probe_pin == 4'h0)
        else $error("probe raised while the program is halted");
    AST_CLEAR_ONE: assert property ( // RULE6
        reg_wr && is_ofs(reg_addr, btm_pkg::OFS_CLR)
        |=> (ena_q & $past(reg_wdata[btm_pkg::NCH-1:0])) == 4'h0)
        else $error("cleared channel still enabled");
    AST_ENA_WRITE: assert property ( // RULE3
        reg_wr && is_ofs(reg_addr, btm_pkg::OFS_ENA)
        |=> ena_q == $past(reg_wdata[btm_pkg::NCH-1:0]))
        else $error("enable write did not land");
    AST_RD_ONCE: assert property (
        !reg_rd |=> reg_rdata == 32'h00000000)
        else $error("read data outside the answer cycle");

    COV_HIT: cover property (hit[3] ##1 probe_pin[3]);
    COV_RECORD: cover property (run_start ##[1:50] rec_en);
    COV_WRAP: cover property (rec_en && wptr_q == 15'h7FFF);
    COV_CLEAR: cover property (reg_wr && is_ofs(reg_addr, btm_pkg::OFS_CLR));
    COV_LONG: cover property (cyc_end && slen_q > btm_pkg::CLK_MAX);

endmodule : btm_monitor

/* File: verilog/btm_pkg.sv */
// Package: map, record layout and reset values of the bus trigger/trace monitor
package btm_pkg;
    localparam int NCH = 4;
    localparam int AW = 24;
    localparam int DW = 16;
    localparam int DEPTH = 32768;
    localparam int PW = 15;
    localparam int CW = 16;
    localparam int REC_W = 49;
    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_ENA = 8'h00;
    localparam logic [7:0] OFS_CLR = 8'h04;
    localparam logic [7:0] OFS_ADDR0 = 8'h10;
    localparam logic [7:0] OFS_ADDR1 = 8'h14;
    localparam logic [7:0] OFS_ADDR2 = 8'h18;
    localparam logic [7:0] OFS_ADDR3 = 8'h1C;
    localparam logic [7:0] OFS_STAT = 8'h20;
    localparam logic [7:0] OFS_CNT = 8'h24;
    localparam logic [7:0] OFS_TSEL = 8'h28;
    localparam logic [7:0] OFS_TLO = 8'h2C;
    localparam logic [7:0] OFS_THI = 8'h30;
    // Clear register fields
    localparam int CLR_ALL_BIT = 4;
    // Synchroniser vector positions
    localparam int SY_ADDR = 0;
    localparam int SY_DATA = 24;
    localparam int SY_WR = 40;
    localparam int SY_STRB = 41;
    localparam int SY_RUN = 42;
    localparam int SY_W = 43;
    // Trace record fields
    localparam int REC_ADDR = 0;
    localparam int REC_DATA = 24;
    localparam int REC_WR = 40;
    localparam int REC_PRB = 41;
    localparam int REC_CLK = 45;
    // Bus cycle length coding: 1..8 direct, overflow code otherwise
    localparam logic [3:0] CLK_MAX = 4'h8;
    localparam logic [3:0] CLK_SAT = 4'h9;
    localparam logic [3:0] CLK_OVR = 4'h0;
    // Reset values
    localparam logic [NCH-1:0] ENA_RST = 4'h0;
    localparam logic [AW-1:0] ADDR_RST = 24'h000000;
    localparam logic [PW-1:0] PTR_RST = 15'h0000;
    localparam logic [CW-1:0] CNT_RST = 16'h0000;
    localparam logic [CW-1:0] CNT_FULL = 16'h8000;
    localparam logic [31:0] RD_RST = 32'h00000000;
endpackage : btm_pkg
